// file: core/dsrl_core.sv
// drive safety request logic: request inputs to gate, brake and fault outputs
// assumes synchronous inputs, a 50 MHz clock and a classic Wishbone master
// What this block does
// - enable low forces outputs and diagnostic zero
// - unconnected enable or axis id: outputs off
// - torque-off request low disables both gate channels
// - single-channel request disables configured channel only
// - brake request low removes brake power
// - brake function waits configurable microsecond delay
// - operating-stop low monitors speed and position tolerance
// - evaluation error while monitoring enters fail-safe
// - several monitors use the lowest speed limit
// - unordered speed limits latch fail-safe until restart
// - stop-one ramps, then disables gate pulses
// - unconnected request input disables its function
// - limit violation: fail-safe, error output low, torque-free
// - statically high acknowledge is flagged as error
`timescale 1ns/1ns
`default_nettype none
module dsrl_core #(
	parameter int ACK_STUCK_US = dsrl_pkg::ACK_STUCK_US
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        activate_i,
	input  wire logic        activate_conn_i,
	input  wire logic [7:0]  axis_identifier_input_i,
	input  wire logic        axis_id_conn_i,
	input  wire logic        torque_off_request_i,
	input  wire logic        torque_off_request_conn_i,
	input  wire logic        single_channel_torque_off_request_i,
	input  wire logic        single_channel_torque_off_request_conn_i,
	input  wire logic        brake_control_request_i,
	input  wire logic        brake_control_request_conn_i,
	input  wire logic        operating_stop_request_i,
	input  wire logic        operating_stop_request_conn_i,
	input  wire logic        ramped_stop_one_request_i,
	input  wire logic        ramped_stop_one_request_conn_i,
	input  wire logic        ack_i,
	input  wire logic        eval_err_i,
	input  wire logic [31:0] speed_i,
	input  wire logic [31:0] position_i,
	input  wire logic        func_brake_i,
	output logic             gate_upper_enable_o,
	output logic             gate_lower_enable_o,
	output logic             brake_power_o,
	output logic             no_functional_error_output_o,
	output logic [15:0]      diagnostic_word_o,
	output logic             irq_o
);
	logic [31:0] ctrl_ff, brk_dly_ff, spd_tol_ff, pos_tol_ff;
	logic [31:0] lim_ls_ff, lim_max_ff, lim_nom_ff, ramp_us_ff, decel_ff;
	logic [dsrl_pkg::IRQ_W-1:0] irq_st_ff, irq_msk_ff, ev;
	logic        oper, sampled_ff, tick, wr, restart;
	logic        rq_tq, rq_one, rq_brk, rq_hold, rq_s1;
	logic        hold_act, hold_act_ff, brake_safe, ramp_done, mon_act;
	logic        fail_ff, cfg_fail_ff, cfg_bad, viol, ack_prev_ff, ack_stuck_ff;
	logic        tq_off, tq_off_ff, brake_safe_ff, fail_prev_ff, cfg_prev_ff, ackst_prev_ff;
	logic [31:0] spd_abs, pos_ref_ff, pos_diff, pos_abs, spd_lim, ramp_lim_ff;
	logic [31:0] ack_cnt_ff, rd;
	logic [15:0] diag;
	dsrl_pkg::dsrl_s1_e s1_ff, nxt_s1;

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) old[b*8 +: 8] = d[b*8 +: 8];
		end
		return old;
	endfunction : merge

	// enable, its own connection and the axis id connection must be present to operate
	assign oper = activate_i && activate_conn_i && axis_id_conn_i;

	// an open request reads as deselected
	assign rq_tq   = torque_off_request_conn_i ? torque_off_request_i : 1'b1;
	assign rq_one  = single_channel_torque_off_request_conn_i ?
		single_channel_torque_off_request_i : 1'b1;
	assign rq_brk  = brake_control_request_conn_i ? brake_control_request_i : 1'b1;
	assign rq_hold = operating_stop_request_conn_i ? operating_stop_request_i : 1'b1;
	assign rq_s1   = ramped_stop_one_request_conn_i ? ramped_stop_one_request_i : 1'b1;

	// requests are trusted only from the cycle after operation was first seen
	always_ff @(posedge clk_i) begin
		if (rst_i) sampled_ff <= 1'b0;
		else sampled_ff <= oper;
	end

	dsrl_tick u_tick (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (tick)
	);

	// wishbone: registered ack, write lands on the acking edge
	assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign restart = wr && (wb_adr_i == dsrl_pkg::REG_CTRL) && wb_sel_i[0] &&
		wb_dat_i[dsrl_pkg::CTRL_RESTART];
	always_ff @(posedge clk_i) begin
		if (rst_i) wb_ack_o <= 1'b0;
		else wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
	end

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff    <= dsrl_pkg::RST_ZERO;
			brk_dly_ff <= dsrl_pkg::RST_ZERO;
			spd_tol_ff <= dsrl_pkg::RST_ZERO;
			pos_tol_ff <= dsrl_pkg::RST_ZERO;
			lim_ls_ff  <= dsrl_pkg::RST_ZERO;
			lim_max_ff <= dsrl_pkg::RST_LIM_MAX;
			lim_nom_ff <= dsrl_pkg::RST_LIM_NOM;
			ramp_us_ff <= dsrl_pkg::RST_ZERO;
			decel_ff   <= dsrl_pkg::RST_ZERO;
			irq_msk_ff <= '0;
		end else if (wr) begin
			case (wb_adr_i)
				dsrl_pkg::REG_CTRL:    ctrl_ff    <= merge(ctrl_ff, wb_dat_i, wb_sel_i) &
					32'h0000_0005; // restart bit is a strobe, not stored
				dsrl_pkg::REG_BRK_DLY: brk_dly_ff <= merge(brk_dly_ff, wb_dat_i, wb_sel_i);
				dsrl_pkg::REG_SPD_TOL: spd_tol_ff <= merge(spd_tol_ff, wb_dat_i, wb_sel_i);
				dsrl_pkg::REG_POS_TOL: pos_tol_ff <= merge(pos_tol_ff, wb_dat_i, wb_sel_i);
				dsrl_pkg::REG_LIM_LS:  lim_ls_ff  <= merge(lim_ls_ff, wb_dat_i, wb_sel_i);
				dsrl_pkg::REG_LIM_MAX: lim_max_ff <= merge(lim_max_ff, wb_dat_i, wb_sel_i);
				dsrl_pkg::REG_LIM_NOM: lim_nom_ff <= merge(lim_nom_ff, wb_dat_i, wb_sel_i);
				dsrl_pkg::REG_RAMP_US: ramp_us_ff <= merge(ramp_us_ff, wb_dat_i, wb_sel_i);
				dsrl_pkg::REG_DECEL:   decel_ff   <= merge(decel_ff, wb_dat_i, wb_sel_i);
				dsrl_pkg::REG_IRQ_MSK: if (wb_sel_i[0]) irq_msk_ff <= wb_dat_i[dsrl_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// read mux; unmapped offsets read zero and still ack
	always_comb begin
		case (wb_adr_i)
			dsrl_pkg::REG_CTRL:    rd = ctrl_ff;
			dsrl_pkg::REG_BRK_DLY: rd = brk_dly_ff;
			dsrl_pkg::REG_SPD_TOL: rd = spd_tol_ff;
			dsrl_pkg::REG_POS_TOL: rd = pos_tol_ff;
			dsrl_pkg::REG_LIM_LS:  rd = lim_ls_ff;
			dsrl_pkg::REG_LIM_MAX: rd = lim_max_ff;
			dsrl_pkg::REG_LIM_NOM: rd = lim_nom_ff;
			dsrl_pkg::REG_RAMP_US: rd = ramp_us_ff;
			dsrl_pkg::REG_DECEL:   rd = decel_ff;
			dsrl_pkg::REG_STATUS:  rd = {25'h000_0000, s1_ff, ack_stuck_ff, cfg_fail_ff,
				fail_ff, sampled_ff, oper};
			dsrl_pkg::REG_IRQ_ST:  rd = {27'h000_0000, irq_st_ff};
			dsrl_pkg::REG_IRQ_MSK: rd = {27'h000_0000, irq_msk_ff};
			dsrl_pkg::REG_DIAG:    rd = {16'h0000, diagnostic_word_o};
			default:               rd = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) wb_dat_o <= 32'h0000_0000;
		else wb_dat_o <= rd;
	end

	// brake function starts only after the configured delay
	dsrl_us_timer u_brk (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.run_i   (!rq_brk && sampled_ff),
		.tick_i  (tick),
		.limit_i (brk_dly_ff),
		.done_o  (brake_safe)
	);

	// standstill reference is taken when operating stop is entered
	assign hold_act = !rq_hold && sampled_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_act_ff <= 1'b0;
			pos_ref_ff  <= 32'h0000_0000;
		end else begin
			hold_act_ff <= hold_act;
			if (hold_act && !hold_act_ff) pos_ref_ff <= position_i;
		end
	end

	assign spd_abs  = speed_i[31] ? 32'(-speed_i) : speed_i;
	assign pos_diff = 32'(position_i - pos_ref_ff);
	assign pos_abs  = pos_diff[31] ? 32'(-pos_diff) : pos_diff;

	// stop one: ramp monitoring, then torque off
	dsrl_us_timer u_ramp (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.run_i   (s1_ff == dsrl_pkg::DSRL_S1_RAMP),
		.tick_i  (tick),
		.limit_i (ramp_us_ff),
		.done_o  (ramp_done)
	);

	always_comb begin
		nxt_s1 = s1_ff;
		case (s1_ff)
			dsrl_pkg::DSRL_S1_IDLE: if (!rq_s1 && sampled_ff) nxt_s1 = dsrl_pkg::DSRL_S1_RAMP;
			dsrl_pkg::DSRL_S1_RAMP: if (rq_s1) nxt_s1 = dsrl_pkg::DSRL_S1_IDLE;
				else if (ramp_done) nxt_s1 = dsrl_pkg::DSRL_S1_DONE;
			dsrl_pkg::DSRL_S1_DONE: if (rq_s1) nxt_s1 = dsrl_pkg::DSRL_S1_IDLE;
			default: nxt_s1 = dsrl_pkg::DSRL_S1_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !oper) s1_ff <= dsrl_pkg::DSRL_S1_IDLE;
		else s1_ff <= nxt_s1;
	end

	// ramp envelope falls by the deceleration each microsecond, floored at zero
	always_ff @(posedge clk_i) begin
		if (rst_i) ramp_lim_ff <= 32'h0000_0000;
		else if (s1_ff == dsrl_pkg::DSRL_S1_IDLE) ramp_lim_ff <= spd_abs;
		else if (tick) ramp_lim_ff <= (ramp_lim_ff > decel_ff) ?
			32'(ramp_lim_ff - decel_ff) : 32'h0000_0000;
	end

	// lowest limit of the active speed monitors wins
	assign spd_lim = (hold_act && spd_tol_ff < lim_max_ff) ? spd_tol_ff : lim_max_ff;
	assign mon_act = hold_act || (s1_ff == dsrl_pkg::DSRL_S1_RAMP);
	assign viol    = mon_act && (spd_abs > spd_lim ||
		(hold_act && pos_abs > pos_tol_ff) ||
		(s1_ff == dsrl_pkg::DSRL_S1_RAMP && spd_abs > ramp_lim_ff));

	// static acknowledge: high for the whole window is an error, not a reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_prev_ff  <= 1'b0;
			ack_cnt_ff   <= 32'h0000_0000;
			ack_stuck_ff <= 1'b0;
		end else begin
			ack_prev_ff <= ack_i;
			if (!ack_i) ack_cnt_ff <= 32'h0000_0000;
			else if (tick && !ack_stuck_ff) ack_cnt_ff <= ack_cnt_ff + 32'h0000_0001;
			ack_stuck_ff <= ack_i && (ack_stuck_ff || ack_cnt_ff >= 32'(ACK_STUCK_US));
		end
	end

	// functional fail-safe: a fault in the clearing cycle keeps it set
	always_ff @(posedge clk_i) begin
		if (rst_i) fail_ff <= 1'b0;
		else if (viol || (mon_act && eval_err_i)) fail_ff <= 1'b1;
		else if (ack_i && !ack_prev_ff && !ack_stuck_ff) fail_ff <= 1'b0;
	end

	// configuration order check; leaves only by a restart over valid settings
	assign cfg_bad = !(spd_tol_ff <= lim_ls_ff && lim_ls_ff <= lim_max_ff &&
		lim_max_ff < lim_nom_ff);
	always_ff @(posedge clk_i) begin
		if (rst_i) cfg_fail_ff <= 1'b0;
		else if (cfg_bad) cfg_fail_ff <= 1'b1;
		else if (restart) cfg_fail_ff <= 1'b0;
	end

	// both channels off for any full stop
	assign tq_off = !sampled_ff || fail_ff || cfg_fail_ff || !rq_tq ||
		(s1_ff == dsrl_pkg::DSRL_S1_DONE);

	// pin outputs; enable low or missing connection forces every one low
	always_ff @(posedge clk_i) begin
		if (rst_i || !oper) begin
			gate_upper_enable_o          <= 1'b0;
			gate_lower_enable_o          <= 1'b0;
			brake_power_o                <= 1'b0;
			no_functional_error_output_o <= 1'b0;
		end else begin
			gate_upper_enable_o <= !tq_off &&
				!(!rq_one && !ctrl_ff[dsrl_pkg::CTRL_CH_LOWER]);
			gate_lower_enable_o <= !tq_off &&
				!(!rq_one && ctrl_ff[dsrl_pkg::CTRL_CH_LOWER]);
			brake_power_o <= func_brake_i && sampled_ff && !brake_safe &&
				!cfg_fail_ff && !(fail_ff && ctrl_ff[dsrl_pkg::CTRL_BRK_FAIL]);
			no_functional_error_output_o <= !fail_ff && !cfg_fail_ff;
		end
	end

	// diagnostic word
	always_comb begin
		diag = dsrl_pkg::DIAG_OFF;
		diag[dsrl_pkg::DG_TQ_OFF]  = !rq_tq;
		diag[dsrl_pkg::DG_ONE_CH]  = !rq_one;
		diag[dsrl_pkg::DG_BRAKE]   = brake_safe;
		diag[dsrl_pkg::DG_HOLD]    = hold_act;
		diag[dsrl_pkg::DG_S1_RAMP] = (s1_ff == dsrl_pkg::DSRL_S1_RAMP);
		diag[dsrl_pkg::DG_S1_DONE] = (s1_ff == dsrl_pkg::DSRL_S1_DONE);
		diag[dsrl_pkg::DG_FAIL]    = fail_ff;
		diag[dsrl_pkg::DG_CFG]     = cfg_fail_ff;
		diag[dsrl_pkg::DG_ACK]     = ack_stuck_ff;
		diag[dsrl_pkg::DG_EVAL]    = eval_err_i;
		diag[dsrl_pkg::DG_ACTIVE]  = 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !oper) diagnostic_word_o <= dsrl_pkg::DIAG_OFF;
		else diagnostic_word_o <= diag;
	end

	// event edges for the interrupt status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fail_prev_ff  <= 1'b0;
			cfg_prev_ff   <= 1'b0;
			ackst_prev_ff <= 1'b0;
			tq_off_ff     <= 1'b0;
			brake_safe_ff <= 1'b0;
		end else begin
			fail_prev_ff  <= fail_ff;
			cfg_prev_ff   <= cfg_fail_ff;
			ackst_prev_ff <= ack_stuck_ff;
			tq_off_ff     <= tq_off && sampled_ff;
			brake_safe_ff <= brake_safe;
		end
	end

	assign ev[dsrl_pkg::EV_FAIL]   = fail_ff && !fail_prev_ff;
	assign ev[dsrl_pkg::EV_CFG]    = cfg_fail_ff && !cfg_prev_ff;
	assign ev[dsrl_pkg::EV_ACK]    = ack_stuck_ff && !ackst_prev_ff;
	assign ev[dsrl_pkg::EV_TQ_OFF] = tq_off && sampled_ff && !tq_off_ff;
	assign ev[dsrl_pkg::EV_BRAKE]  = brake_safe && !brake_safe_ff;

	// write one to clear; a new event in the same cycle stays set
	always_ff @(posedge clk_i) begin
		if (rst_i) irq_st_ff <= '0;
		else if (wr && wb_adr_i == dsrl_pkg::REG_IRQ_ST && wb_sel_i[0])
			irq_st_ff <= (irq_st_ff & ~wb_dat_i[dsrl_pkg::IRQ_W-1:0]) | ev;
		else irq_st_ff <= irq_st_ff | ev;
	end

	assign irq_o = |(irq_st_ff & irq_msk_ff);

	// checks
	AST_ENABLE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		!activate_i |=> !gate_upper_enable_o && !brake_power_o && diagnostic_word_o == 16'h0000)
		else $error("outputs not cleared while disabled");
	AST_NO_AXIS: assert property (@(posedge clk_i) disable iff (rst_i)
		!axis_id_conn_i |=> !gate_lower_enable_o && !brake_power_o)
		else $error("outputs live without axis id");
	AST_TQ_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		torque_off_request_conn_i && !torque_off_request_i |=>
		!gate_upper_enable_o && !gate_lower_enable_o)
		else $error("gates live under torque-off");
	AST_ONE_CH: assert property (@(posedge clk_i) disable iff (rst_i)
		single_channel_torque_off_request_conn_i && !single_channel_torque_off_request_i &&
		!ctrl_ff[dsrl_pkg::CTRL_CH_LOWER] |=> !gate_upper_enable_o)
		else $error("upper channel live under one-channel stop");
	AST_BRAKE: assert property (@(posedge clk_i) disable iff (rst_i)
		brake_safe |=> !brake_power_o)
		else $error("brake powered while brake function active");
	AST_BRK_DELAY: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(!rq_brk && sampled_ff) && brk_dly_ff > 32'h0 |-> !brake_safe)
		else $error("brake function ignored delay");
	AST_FAIL_EVAL: assert property (@(posedge clk_i) disable iff (rst_i)
		mon_act && eval_err_i |=> fail_ff ##1 !no_functional_error_output_o)
		else $error("evaluation error did not fail safe");
	AST_CFG: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_fail_ff && !restart |=> cfg_fail_ff)
		else $error("configuration fail-safe left without restart");
	AST_S1: assert property (@(posedge clk_i) disable iff (rst_i)
		s1_ff == dsrl_pkg::DSRL_S1_DONE |=> !gate_upper_enable_o)
		else $error("gates live after stop one");
	AST_ACK_STUCK: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_stuck_ff |-> $past(ack_i) && !$fell(fail_ff))
		else $error("stuck acknowledge cleared fail-safe");
	AST_SAMPLED: assert property (@(posedge clk_i) disable iff (rst_i)
		!sampled_ff |=> !gate_upper_enable_o && !brake_power_o)
		else $error("outputs live before sampling");
	COV_TQ_OFF: cover property (@(posedge clk_i) disable iff (rst_i) $fell(gate_upper_enable_o));
	COV_S1: cover property (@(posedge clk_i) disable iff (rst_i)
		s1_ff == dsrl_pkg::DSRL_S1_RAMP ##1 s1_ff == dsrl_pkg::DSRL_S1_DONE);
	COV_FAIL_ACK: cover property (@(posedge clk_i) disable iff (rst_i) $fell(fail_ff));
endmodule : dsrl_core
`default_nettype wire

// file: core/dsrl_pkg.sv
// constants for the drive safety request logic
// assumes a 50 MHz clock and a byte-addressed classic Wishbone register bus
package dsrl_pkg;
	// time base
	localparam int CLK_PERIOD_NS = 20;
	localparam int US_NS         = 1000;
	localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// static acknowledge detection window in microseconds
	localparam int ACK_STUCK_US  = 1000;

	// register byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_BRK_DLY = 8'h04;
	localparam logic [7:0] REG_SPD_TOL = 8'h08;
	localparam logic [7:0] REG_POS_TOL = 8'h0c;
	localparam logic [7:0] REG_LIM_LS  = 8'h10;
	localparam logic [7:0] REG_LIM_MAX = 8'h14;
	localparam logic [7:0] REG_LIM_NOM = 8'h18;
	localparam logic [7:0] REG_RAMP_US = 8'h1c;
	localparam logic [7:0] REG_DECEL   = 8'h20;
	localparam logic [7:0] REG_STATUS  = 8'h24;
	localparam logic [7:0] REG_IRQ_ST  = 8'h28;
	localparam logic [7:0] REG_IRQ_MSK = 8'h2c;
	localparam logic [7:0] REG_DIAG    = 8'h30;

	// control fields
	localparam int CTRL_CH_LOWER  = 0;
	localparam int CTRL_RESTART   = 1;
	localparam int CTRL_BRK_FAIL  = 2;

	// reset values
	localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
	localparam logic [31:0] RST_LIM_MAX = 32'h0000_8000;
	localparam logic [31:0] RST_LIM_NOM = 32'h0000_ffff;

	// diagnostic word fields
	localparam int DG_TQ_OFF   = 0;
	localparam int DG_ONE_CH   = 1;
	localparam int DG_BRAKE    = 2;
	localparam int DG_HOLD     = 3;
	localparam int DG_S1_RAMP  = 4;
	localparam int DG_S1_DONE  = 5;
	localparam int DG_FAIL     = 8;
	localparam int DG_CFG      = 9;
	localparam int DG_ACK      = 10;
	localparam int DG_EVAL     = 11;
	localparam int DG_ACTIVE   = 15;
	localparam logic [15:0] DIAG_OFF = 16'h0000;

	// interrupt event bits
	localparam int IRQ_W      = 5;
	localparam int EV_FAIL    = 0;
	localparam int EV_CFG     = 1;
	localparam int EV_ACK     = 2;
	localparam int EV_TQ_OFF  = 3;
	localparam int EV_BRAKE   = 4;

	typedef enum logic [1:0] {
		DSRL_S1_IDLE = 2'b00,
		DSRL_S1_RAMP = 2'b01,
		DSRL_S1_DONE = 2'b10
	} dsrl_s1_e;
endpackage : dsrl_pkg

// file: core/dsrl_tick.sv
// microsecond enable generator
// assumes one clock; the pulse lasts one cycle
`timescale 1ns/1ns
`default_nettype none
module dsrl_tick (
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      tick_o
);
	logic [7:0] cnt_ff;

	// divider by the cycles in one microsecond
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= 8'h00;
			tick_o <= 1'b0;
		end else if (cnt_ff == 8'(dsrl_pkg::CYC_PER_US - 1)) begin
			cnt_ff <= 8'h00;
			tick_o <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
			tick_o <= 1'b0;
		end
	end
endmodule : dsrl_tick
`default_nettype wire

// file: core/dsrl_us_timer.sv
// microsecond delay timer: done rises once run has lasted limit ticks
// assumes tick_i is a one-cycle microsecond enable
`timescale 1ns/1ns
`default_nettype none
module dsrl_us_timer (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        run_i,
	input  wire logic        tick_i,
	input  wire logic [31:0] limit_i,
	output logic             done_o
);
	logic [31:0] cnt_ff;

	// counter saturates so a long request never wraps back to not done
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_ff <= 32'h0000_0000;
		end else if (tick_i && !done_o) begin
			cnt_ff <= cnt_ff + 32'h0000_0001;
		end
	end

	// a zero limit is done as soon as run is seen
	assign done_o = run_i && (cnt_ff >= limit_i);
endmodule : dsrl_us_timer
`default_nettype wire

// file: testbench/dsrl_ctrl_model.sv
// partner model: the safety controller application driving the request pins
// assumes the bench commands the request levels and which functions are wired
`timescale 1ns/1ns
`default_nettype none
module dsrl_ctrl_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [4:0] lvl_i,
	input  wire logic [4:0] use_i,
	output logic      [4:0] req_o,
	output logic      [4:0] conn_o
);
	// an open pin floats: it toggles so a stale level never passes for valid
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_o  <= 5'h00;
			conn_o <= 5'h00;
		end else begin
			conn_o <= use_i;
			req_o  <= (lvl_i & use_i) | (~use_i & ~req_o);
		end
	end
endmodule : dsrl_ctrl_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the drive safety request logic
// assumes the request pins come from the controller model, one 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0]  wb_adr_i = 8'h00, axis_identifier_input_i = 8'h01;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, speed_i = 32'h0, position_i = 32'h0, wb_dat_o, q;
	logic        wb_ack_o, gate_upper_enable_o, gate_lower_enable_o, brake_power_o, irq_o;
	logic        no_functional_error_output_o, func_brake_i = 0, eval_err_i = 0, ack_i = 0;
	logic        activate_i = 0, activate_conn_i = 0, axis_id_conn_i = 0;
	logic [15:0] diagnostic_word_o;
	logic        torque_off_request_i, single_channel_torque_off_request_i;
	logic        brake_control_request_i, operating_stop_request_i, ramped_stop_one_request_i;
	logic        torque_off_request_conn_i, single_channel_torque_off_request_conn_i;
	logic        brake_control_request_conn_i, operating_stop_request_conn_i;
	logic        ramped_stop_one_request_conn_i;
	logic [4:0]  lvl = 5'h1f, use_r = 5'h1f;
	int          bad_count = 0, compares = 0;

	// 50 MHz clock
	always #10 clk_i = ~clk_i;

	dsrl_core #(.ACK_STUCK_US(3)) dut (.*);
	dsrl_ctrl_model ctl (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(lvl), .use_i(use_r),
		.req_o({ramped_stop_one_request_i, operating_stop_request_i, brake_control_request_i,
			single_channel_torque_off_request_i, torque_off_request_i}),
		.conn_o({ramped_stop_one_request_conn_i, operating_stop_request_conn_i,
			brake_control_request_conn_i, single_channel_torque_off_request_conn_i,
			torque_off_request_conn_i}));

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_n

	// one classic cycle; hold everything until ack is sampled
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			final_report();
		end
		@(posedge clk_i);
	endtask : wb

	task automatic ack_pulse;
		ack_i <= 1'b1;
		@(posedge clk_i);
		ack_i <= 1'b0;
		wait_n(5);
	endtask : ack_pulse

	// main sequence
	initial begin
		wait_n(20);
		chk(gate_upper_enable_o, 0);
		chk(brake_power_o, 0);
		rst_i <= 1'b0;
		activate_i <= 1'b1;
		activate_conn_i <= 1'b1;
		axis_id_conn_i <= 1'b1;
		func_brake_i <= 1'b1;
		@(posedge clk_i);
		wb(0, dsrl_pkg::REG_LIM_MAX, 0);
		chk(q, dsrl_pkg::RST_LIM_MAX);
		wb(0, dsrl_pkg::REG_BRK_DLY, 0);
		chk(q, dsrl_pkg::RST_ZERO);
		wb(1, 8'h3c, 32'hffff_ffff);
		wb(0, 8'h3c, 0);
		chk(q, 32'h0);
		chk(gate_upper_enable_o, 1);
		chk(brake_power_o, 1);
		lvl <= 5'h00;
		use_r <= 5'h00;
		wait_n(5);
		chk(gate_upper_enable_o, 1);
		chk(brake_power_o, 1);
		use_r <= 5'h1f;
		lvl <= 5'h1e;
		wb(1, dsrl_pkg::REG_IRQ_MSK, 32'h1 << dsrl_pkg::EV_TQ_OFF);
		wait_n(3);
		chk({gate_upper_enable_o, gate_lower_enable_o}, 0);
		chk(irq_o, 1);
		lvl <= 5'h1f;
		wait_n(5);
		chk({gate_upper_enable_o, gate_lower_enable_o}, 3);
		chk(irq_o, 1);
		wb(1, dsrl_pkg::REG_IRQ_ST, 32'h1 << dsrl_pkg::EV_TQ_OFF);
		chk(irq_o, 0);
		// channel choice: upper by default, then lower
		for (int c = 0; c < 2; c++) begin
			wb(1, dsrl_pkg::REG_CTRL, 32'(c));
			lvl <= 5'h1d;
			wait_n(5);
			chk({gate_upper_enable_o, gate_lower_enable_o}, 32'(1 + c));
			lvl <= 5'h1f;
			wait_n(5);
		end
		wb(1, dsrl_pkg::REG_BRK_DLY, 32'h2);
		lvl <= 5'h1b;
		wait_n(50);
		chk(brake_power_o, 1);
		wait_n(110);
		chk(brake_power_o, 0);
		lvl <= 5'h1f;
		wait_n(5);
		chk(brake_power_o, 1);
		func_brake_i <= 1'b0;
		wait_n(3);
		chk(brake_power_o, 0);
		func_brake_i <= 1'b1;
		wait_n(3);
		lvl <= 5'h17;
		wait_n(5);
		chk(no_functional_error_output_o, 1);
		speed_i <= 32'h5;
		wait_n(5);
		chk({no_functional_error_output_o, gate_upper_enable_o}, 0);
		speed_i <= 32'h0;
		lvl <= 5'h1f;
		wait_n(5);
		ack_pulse();
		chk(no_functional_error_output_o, 1);
		lvl <= 5'h17;
		eval_err_i <= 1'b1;
		wait_n(5);
		chk(no_functional_error_output_o, 0);
		eval_err_i <= 1'b0;
		lvl <= 5'h1f;
		wait_n(5);
		ack_pulse();
		wb(1, dsrl_pkg::REG_LIM_MAX, 32'h0001_0000);
		wait_n(5);
		chk({diagnostic_word_o[dsrl_pkg::DG_CFG], gate_upper_enable_o}, 2);
		ack_pulse();
		chk(diagnostic_word_o[dsrl_pkg::DG_CFG], 1);
		wb(1, dsrl_pkg::REG_LIM_MAX, dsrl_pkg::RST_LIM_MAX);
		wb(1, dsrl_pkg::REG_CTRL, 32'h1 << dsrl_pkg::CTRL_RESTART);
		wait_n(5);
		chk({diagnostic_word_o[dsrl_pkg::DG_CFG], gate_upper_enable_o}, 1);
		wb(1, dsrl_pkg::REG_RAMP_US, 32'h2);
		lvl <= 5'h0f;
		wait_n(5);
		chk({diagnostic_word_o[dsrl_pkg::DG_S1_RAMP], gate_upper_enable_o}, 3);
		wait_n(150);
		chk({diagnostic_word_o[dsrl_pkg::DG_S1_DONE], gate_upper_enable_o}, 2);
		lvl <= 5'h1f;
		ack_i <= 1'b1;
		wait_n(200);
		chk(diagnostic_word_o[dsrl_pkg::DG_ACK], 1);
		ack_i <= 1'b0;
		activate_i <= 1'b0;
		wait_n(5);
		chk(diagnostic_word_o, dsrl_pkg::DIAG_OFF);
		chk({gate_upper_enable_o, gate_lower_enable_o, brake_power_o}, 0);
		activate_i <= 1'b1;
		// either open enable or open axis id keeps the power stage off
		for (int k = 0; k < 2; k++) begin
			activate_conn_i <= k[0];
			axis_id_conn_i <= !k[0];
			wait_n(5);
			chk({gate_upper_enable_o, brake_power_o}, 0);
		end
		final_report();
	end
endmodule : tb
`default_nettype wire
